/* File: mfm_sym_map.sv */
// Purpose: Multilevel FSK order select, sync search and symbol mapping
// Assumes: Receive levels are hard decisions; one symbol per rx_vld_i
// Notes:
// Operation
// RL1: Symbol rate at most 20 ksymbols/s
// RL2: Root raised cosine shaping, roll-off 0.2
// RL3: Formatted blocks up to 48 bytes, CRC 8/16/32
// RL4: Preamble and sync sent as 4-level above 2-level
// RL5: 2-level: 2/4-level sync, no FEC
// RL6: Fixed receive uses payload_modulation_select order
// RL7: Sync-selected mode: detected sync picks order
// RL8: Mode bits 11-8 choose the sync search
// RL9: 2-level: 0 is -3, 1 is +3
// RL10: 4-level: 00,01,10,11 to -1,-3,+1,+3
// RL11: Legacy block types only with 4-level
// RL12: 8-level: sign bit, magnitudes 1,3,7,5
// RL13: 16-level: sign bit, magnitudes 1,3,7,5,15,13,9,11
// RL14: Outermost symbols share one peak deviation
// RL15: Host writes only listed search codes
`timescale 1ns/1ps
`default_nettype none
`include "mfm_defs.svh"
module mfm_sym_map #(
    parameter int MIN_SYM_CYC = `MFM_CLK_HZ / `MFM_MAX_SYM_RATE
) (
    input  wire logic               mclk_i,
    input  wire logic               sys_rst_i,
    input  wire logic [7:0]         reg_addr_i,
    input  wire logic [31:0]        reg_wdata_i,
    input  wire logic               reg_wr_i,
    input  wire logic               reg_rd_i,
    output logic      [31:0]        reg_rdata_o,
    input  wire logic [3:0]         tx_bits_i,
    input  wire logic               tx_hdr_i,
    input  wire logic               tx_vld_i,
    output logic                    tx_rdy_o,
    output logic signed [17:0]      mod_o,
    output logic                    mod_vld_o,
    input  wire logic signed [4:0]  rx_lvl_i,
    input  wire logic               rx_vld_i,
    output logic      [3:0]         rx_bits_o,
    output logic      [2:0]         rx_nbits_o,
    output logic                    rx_vld_o,
    output logic      [1:0]         rx_ord_o,
    output logic                    fec_en_o,
    output logic                    legacy_en_o,
    output logic      [1:0]         crc_sel_o,
    output logic      [5:0]         blk_len_o
);
    localparam logic [15:0] MIN_PER = 16'(MIN_SYM_CYC);

    if (MIN_SYM_CYC < 4 || MIN_SYM_CYC > 65535) begin : g_bad_cyc
        $error("MIN_SYM_CYC out of range");
    end

    typedef enum logic [1:0] {RX_IDLE, RX_SRCH, RX_PAY} mfm_rx_state_t;

    mfm_xlat_if xif ();

    mfm_xlat u_xlat (
        .x (xif.xlat)
    );

    logic [31:0]          mode_r, modsel_r, syncmap_r, sync1_r, sync2_r, rdata_r, sr_r;
    logic [15:0]          per_r, rxlen_r, cnt_r, pay_cnt_r;
    logic                 hit1_r, hit2_r, sym_stb_r, mid_stb_r, slot_full_r, slot_hdr_r;
    logic                 tx_rdy_r, push_r, rx_vld_r, fec_r, legacy_r;
    logic [3:0]           slot_bits_r, rx_bits_r;
    logic signed [7:0]    dl_r [0:8];
    logic signed [17:0]   mod_r;
    mfm_rx_state_t        rx_st_r;
    logic [5:0]           fill_r, blk_r;
    mfm_pkg::mfm_order_t  pay_ord_r;
    logic [2:0]           rx_nb_r;
    logic [1:0]           crc_r;

    mfm_pkg::mfm_order_t  sel_ord, hdr_ord, s1_ord, s2_ord, eff_ord;
    mfm_pkg::mfm_srch_t   srch;
    logic                 tx_en, take, restart, hit1, hit2;
    logic [31:0]          sr_nxt, status;
    logic [5:0]           fill_nxt, blk_req;
    logic [2:0]           rx_n;
    logic signed [17:0]   acc;

    // Decoded controls
    always_comb begin
        sel_ord = mfm_pkg::mfm_order_t'(modsel_r[`MFM_MODSEL_ORD +: 2]);
        s1_ord  = mfm_pkg::mfm_order_t'(syncmap_r[`MFM_MAP_S1 +: 2]);
        s2_ord  = mfm_pkg::mfm_order_t'(syncmap_r[`MFM_MAP_S2 +: 2]);
        hdr_ord = (sel_ord == mfm_pkg::MFM_ORD_2 && modsel_r[`MFM_MODSEL_PRE2])
                  ? mfm_pkg::MFM_ORD_2 : mfm_pkg::MFM_ORD_4; // RL4 RL5
        srch    = mfm_pkg::mfm_srch_dec(mode_r[`MFM_MODE_SRCH_LSB +: 4]); // RL8
        tx_en   = mode_r[`MFM_MODE_TXEN];
        take    = tx_vld_i & tx_rdy_r;
        restart = reg_wr_i && reg_addr_i <= `MFM_OFS_SYNC2 && reg_addr_i[1:0] == 2'h0;
        eff_ord = (!tx_en && rx_st_r == RX_PAY) ? pay_ord_r : sel_ord;
        blk_req = mode_r[`MFM_MODE_BLK_LSB +: 6];
    end

    // Register writes
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            mode_r    <= `MFM_RST_MODE;
            modsel_r  <= `MFM_RST_MODSEL;
            syncmap_r <= `MFM_RST_SYNCMAP;
            sync1_r   <= `MFM_RST_SYNC1;
            sync2_r   <= `MFM_RST_SYNC2;
            per_r     <= MIN_PER;
            rxlen_r   <= `MFM_RST_RXLEN;
        end else if (reg_wr_i) begin
            unique case (reg_addr_i)
                `MFM_OFS_MODE:    mode_r    <= reg_wdata_i;
                `MFM_OFS_MODSEL:  modsel_r  <= {29'h0, reg_wdata_i[2:0]};
                `MFM_OFS_SYNCMAP: syncmap_r <= {28'h0, reg_wdata_i[3:0]};
                `MFM_OFS_SYNC1:   sync1_r   <= reg_wdata_i;
                `MFM_OFS_SYNC2:   sync2_r   <= reg_wdata_i;
                `MFM_OFS_SYMPER: begin
                    per_r <= (reg_wdata_i[15:0] < MIN_PER) ? MIN_PER : reg_wdata_i[15:0]; // RL1
                end
                `MFM_OFS_RXLEN: begin
                    rxlen_r <= (reg_wdata_i[15:0] == 16'h0000) ? 16'h0001 : reg_wdata_i[15:0];
                end
                default: ;
            endcase
        end
    end

    // Sticky sync flags, write one to clear, a new hit wins
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            hit1_r <= 1'b0;
            hit2_r <= 1'b0;
        end else begin
            if (reg_wr_i && reg_addr_i == `MFM_OFS_STATUS) begin
                hit1_r <= hit1_r & ~reg_wdata_i[`MFM_ST_HIT1];
                hit2_r <= hit2_r & ~reg_wdata_i[`MFM_ST_HIT2];
            end
            if (rx_st_r == RX_SRCH && rx_vld_i && hit1) begin
                hit1_r <= 1'b1;
            end
            if (rx_st_r == RX_SRCH && rx_vld_i && !hit1 && hit2) begin
                hit2_r <= 1'b1;
            end
        end
    end

    always_comb begin
        status = 32'h0000_0000;
        status[`MFM_ST_STATE +: 2] = rx_st_r;
        status[`MFM_ST_HIT1]       = hit1_r;
        status[`MFM_ST_HIT2]       = hit2_r;
        status[`MFM_ST_ORD +: 2]   = eff_ord;
        status[`MFM_ST_BADCODE]    = ~srch.ok; // RL15
        status[`MFM_ST_BLKLONG]    = blk_req > `MFM_MAX_BLK_BYTES;
    end

    // Read data for one cycle
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || !reg_rd_i) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            unique case (reg_addr_i)
                `MFM_OFS_MODE:    rdata_r <= mode_r;
                `MFM_OFS_MODSEL:  rdata_r <= modsel_r;
                `MFM_OFS_SYNCMAP: rdata_r <= syncmap_r;
                `MFM_OFS_SYNC1:   rdata_r <= sync1_r;
                `MFM_OFS_SYNC2:   rdata_r <= sync2_r;
                `MFM_OFS_SYMPER:  rdata_r <= {16'h0000, per_r};
                `MFM_OFS_RXLEN:   rdata_r <= {16'h0000, rxlen_r};
                `MFM_OFS_STATUS:  rdata_r <= status;
                default:          rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // Symbol and half-symbol strobes
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cnt_r     <= 16'h0000;
            sym_stb_r <= 1'b0;
            mid_stb_r <= 1'b0;
        end else begin
            cnt_r     <= (cnt_r >= per_r - 16'h0001) ? 16'h0000 : cnt_r + 16'h0001; // RL1
            sym_stb_r <= cnt_r == 16'h0000;
            mid_stb_r <= cnt_r == {1'b0, per_r[15:1]};
        end
    end

    // One-symbol holding slot
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            slot_full_r <= 1'b0;
            slot_bits_r <= 4'h0;
            slot_hdr_r  <= 1'b0;
            tx_rdy_r    <= 1'b0;
        end else begin
            if (take) begin
                slot_full_r <= 1'b1;
                slot_bits_r <= tx_bits_i;
                slot_hdr_r  <= tx_hdr_i;
            end else if (sym_stb_r || !tx_en) begin
                slot_full_r <= 1'b0;
            end
            tx_rdy_r <= tx_en && !take && (!slot_full_r || sym_stb_r);
        end
    end

    always_comb begin
        xif.tx_ord  = slot_hdr_r ? hdr_ord : sel_ord; // RL4 RL5
        xif.tx_bits = slot_bits_r;
        xif.rx_ord  = (rx_st_r == RX_SRCH) ? hdr_ord : pay_ord_r;
        xif.rx_lvl  = rx_lvl_i;
    end

    // Two-times upsampled pulse shaping line
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            dl_r   <= '{default: 8'sh00};
            push_r <= 1'b0;
        end else begin
            push_r <= sym_stb_r || mid_stb_r;
            if (sym_stb_r || mid_stb_r) begin
                dl_r[0] <= (sym_stb_r && slot_full_r && tx_en) ? xif.tx_scaled : 8'sh00;
                for (int i = 1; i < 9; i++) begin
                    dl_r[i] <= dl_r[i-1];
                end
            end
        end
    end

    always_comb begin
        acc = 18'sh0_0000;
        for (int i = 0; i < 9; i++) begin
            acc = acc + 18'(dl_r[i]) * 18'(mfm_pkg::MFM_RRC[(i < 5) ? i : 8 - i]); // RL2
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            mod_r     <= 18'sh0_0000;
            mod_vld_o <= 1'b0;
        end else begin
            mod_r     <= acc; // RL2 RL14
            mod_vld_o <= push_r;
        end
    end

    // Sync search over the header order
    always_comb begin
        rx_n     = mfm_pkg::mfm_nbits(hdr_ord);
        sr_nxt   = (sr_r << rx_n) | {28'h000_0000, xif.rx_bits};
        fill_nxt = (fill_r + {3'h0, rx_n} >= `MFM_SYNC_BITS) ? `MFM_SYNC_BITS
                   : 6'(fill_r + {3'h0, rx_n});
        hit1     = srch.s1 && fill_nxt == `MFM_SYNC_BITS && sr_nxt == sync1_r; // RL6 RL8
        hit2     = srch.s2 && fill_nxt == `MFM_SYNC_BITS && sr_nxt == sync2_r; // RL6 RL8
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rx_st_r   <= RX_IDLE;
            sr_r      <= 32'h0000_0000;
            fill_r    <= 6'h00;
            pay_cnt_r <= 16'h0000;
            pay_ord_r <= mfm_pkg::MFM_ORD_4;
        end else if (restart || tx_en || !srch.ok) begin
            rx_st_r <= (tx_en || !srch.ok) ? RX_IDLE : RX_SRCH; // RL15
            sr_r    <= 32'h0000_0000;
            fill_r  <= 6'h00;
        end else begin
            unique case (rx_st_r)
                RX_IDLE: rx_st_r <= RX_SRCH;
                RX_SRCH: begin
                    if (rx_vld_i) begin
                        sr_r   <= sr_nxt;
                        fill_r <= fill_nxt;
                        if (hit1 || hit2) begin
                            rx_st_r   <= RX_PAY;
                            pay_cnt_r <= 16'h0000;
                            if (srch.auto_sel) begin
                                pay_ord_r <= hit1 ? s1_ord : s2_ord; // RL7
                            end else begin
                                pay_ord_r <= sel_ord; // RL6
                            end
                        end
                    end
                end
                RX_PAY: begin
                    if (rx_vld_i) begin
                        pay_cnt_r <= pay_cnt_r + 16'h0001;
                        if (pay_cnt_r >= rxlen_r - 16'h0001) begin
                            rx_st_r <= RX_SRCH;
                            sr_r    <= 32'h0000_0000;
                            fill_r  <= 6'h00;
                        end
                    end
                end
            endcase
        end
    end

    // Payload bit groups out
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rx_bits_r <= 4'h0;
            rx_nb_r   <= 3'h0;
            rx_vld_r  <= 1'b0;
        end else begin
            rx_vld_r <= rx_st_r == RX_PAY && rx_vld_i && !restart && !tx_en && srch.ok;
            if (rx_st_r == RX_PAY && rx_vld_i) begin
                rx_bits_r <= xif.rx_bits; // RL6 RL7
                rx_nb_r   <= mfm_pkg::mfm_nbits(pay_ord_r);
            end
        end
    end

    // Coding controls; FEC and legacy gated by the active order
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            fec_r    <= 1'b0;
            legacy_r <= 1'b0;
            crc_r    <= 2'h0;
            blk_r    <= 6'h00;
        end else begin
            fec_r    <= mode_r[`MFM_MODE_FEC] && eff_ord != mfm_pkg::MFM_ORD_2; // RL5
            legacy_r <= mode_r[`MFM_MODE_LEGACY] && eff_ord == mfm_pkg::MFM_ORD_4; // RL11
            crc_r    <= mode_r[`MFM_MODE_CRC_LSB +: 2]; // RL3
            blk_r    <= (blk_req > `MFM_MAX_BLK_BYTES) ? `MFM_MAX_BLK_BYTES : blk_req; // RL3
        end
    end

    always_comb begin
        reg_rdata_o = rdata_r;
        tx_rdy_o    = tx_rdy_r;
        mod_o       = mod_r;
        rx_bits_o   = rx_bits_r;
        rx_nbits_o  = rx_nb_r;
        rx_vld_o    = rx_vld_r;
        rx_ord_o    = pay_ord_r;
        fec_en_o    = fec_r;
        legacy_en_o = legacy_r;
        crc_sel_o   = crc_r;
        blk_len_o   = blk_r;
    end
endmodule : mfm_sym_map
`default_nettype wire

/* File: mfm_defs.svh */
// Purpose: Constants of the FSK symbol map
// Assumes: 32-bit register words on byte addresses
// Notes:   Included by its bare name
`ifndef MFM_DEFS_SVH
`define MFM_DEFS_SVH

`define MFM_OFS_MODE 8'h00
`define MFM_OFS_MODSEL 8'h04
`define MFM_OFS_SYNCMAP 8'h08
`define MFM_OFS_SYNC1 8'h0C
`define MFM_OFS_SYNC2 8'h10
`define MFM_OFS_SYMPER 8'h14
`define MFM_OFS_RXLEN 8'h18
`define MFM_OFS_STATUS 8'h1C
`define MFM_MODE_TXEN 0
`define MFM_MODE_FEC 1
`define MFM_MODE_LEGACY 2
`define MFM_MODE_CRC_LSB 4
`define MFM_MODE_SRCH_LSB 8
`define MFM_MODE_BLK_LSB 16
`define MFM_MODSEL_ORD 0
`define MFM_MODSEL_PRE2 2
`define MFM_MAP_S1 0
`define MFM_MAP_S2 2
`define MFM_ST_STATE 0
`define MFM_ST_HIT1 2
`define MFM_ST_HIT2 3
`define MFM_ST_ORD 4
`define MFM_ST_BADCODE 6
`define MFM_ST_BLKLONG 7
`define MFM_RST_MODE 32'h0000_0200
`define MFM_RST_MODSEL 32'h0000_0001
`define MFM_RST_SYNCMAP 32'h0000_000D
`define MFM_RST_SYNC1 32'h5F5F_A0A0
`define MFM_RST_SYNC2 32'h33CC_C333
`define MFM_RST_RXLEN 16'h0040
`define MFM_CLK_HZ 200000000
`define MFM_MAX_SYM_RATE 20000
`define MFM_MAX_BLK_BYTES 6'h30
`define MFM_SYNC_BITS 6'h20

`endif

/* File: mfm_pkg.sv */
// Purpose: Types and symbol functions
// Assumes: Levels are odd integers in -15..+15
// Notes:   Scoped use only
package mfm_pkg;
    typedef enum logic [1:0] {MFM_ORD_2, MFM_ORD_4, MFM_ORD_8, MFM_ORD_16} mfm_order_t;
    typedef logic signed [4:0] mfm_lvl_t;
    typedef struct packed {
        logic ok;
        logic s1;
        logic s2;
        logic auto_sel;
    } mfm_srch_t;

    // Root raised cosine, alpha 0.2, two samples a symbol, centre tap last
    localparam logic signed [8:0] MFM_RRC [0:4] = '{9'sd6, -9'sd22, -9'sd6, 9'sd76, 9'sd127};

    function automatic logic [2:0] mfm_nbits(input mfm_order_t o);
        return 3'({1'b0, o} + 3'h1);
    endfunction : mfm_nbits

    function automatic logic [3:0] mfm_mag8(input logic [1:0] b);
        unique case (b)
            2'h0: return 4'h1;
            2'h1: return 4'h3;
            2'h2: return 4'h7;
            2'h3: return 4'h5;
        endcase
    endfunction : mfm_mag8

    function automatic mfm_lvl_t mfm_map(input mfm_order_t o, input logic [3:0] b);
        logic [3:0] mag;
        logic       neg;
        mag = 4'h1;
        neg = 1'b0;
        unique case (o)
            MFM_ORD_2: begin
                mag = 4'h3;
                neg = ~b[0];
            end
            MFM_ORD_4: begin
                mag = b[0] ? 4'h3 : 4'h1;
                neg = ~b[1];
            end
            MFM_ORD_8: begin
                mag = mfm_mag8(b[1:0]);
                neg = ~b[2];
            end
            MFM_ORD_16: begin
                mag = b[2] ? 4'(5'h10 - {1'b0, mfm_mag8(b[1:0])}) : mfm_mag8(b[1:0]);
                neg = ~b[3];
            end
        endcase
        return neg ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
    endfunction : mfm_map

    function automatic logic [3:0] mfm_demap(input mfm_order_t o, input mfm_lvl_t l);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 0; i < 16; i++) begin
            if (i < (1 << mfm_nbits(o)) && mfm_map(o, 4'(i)) == l) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction : mfm_demap

    // Outermost level of every order lands on 105
    function automatic logic [6:0] mfm_gain(input mfm_order_t o);
        unique case (o)
            MFM_ORD_2:  return 7'h23;
            MFM_ORD_4:  return 7'h23;
            MFM_ORD_8:  return 7'h0F;
            MFM_ORD_16: return 7'h07;
        endcase
    endfunction : mfm_gain

    function automatic mfm_srch_t mfm_srch_dec(input logic [3:0] c);
        unique case (c)
            4'h2, 4'h9: return mfm_srch_t'(4'hE);
            4'h4, 4'hA: return mfm_srch_t'(4'hC);
            4'h5, 4'hB: return mfm_srch_t'(4'hA);
            4'hD:       return mfm_srch_t'(4'hF);
            default:    return mfm_srch_t'(4'h0);
        endcase
    endfunction : mfm_srch_dec
endpackage : mfm_pkg

/* File: mfm_xlat_if.sv */
// Purpose: Symbol translation signals
// Assumes: Combinational answers
// Notes:   None
`timescale 1ns/1ps
`default_nettype none
interface mfm_xlat_if;
    mfm_pkg::mfm_order_t tx_ord;
    logic [3:0]          tx_bits;
    mfm_pkg::mfm_lvl_t   tx_lvl;
    logic signed [7:0]   tx_scaled;
    mfm_pkg::mfm_order_t rx_ord;
    mfm_pkg::mfm_lvl_t   rx_lvl;
    logic [3:0]          rx_bits;
    modport ctl (output tx_ord, tx_bits, rx_ord, rx_lvl, input tx_lvl, tx_scaled, rx_bits);
    modport xlat (input tx_ord, tx_bits, rx_ord, rx_lvl, output tx_lvl, tx_scaled, rx_bits);
endinterface : mfm_xlat_if
`default_nettype wire

/* File: mfm_xlat.sv */
// Purpose: Bit group to level and back, scaled
// Assumes: Receive levels arrive as hard decisions
// Notes:   Combinational
`timescale 1ns/1ps
`default_nettype none
module mfm_xlat (
    mfm_xlat_if.xlat x
);
    logic signed [12:0] prod;

    always_comb begin
        x.tx_lvl    = mfm_pkg::mfm_map(x.tx_ord, x.tx_bits); // RL9 RL10 RL12 RL13
        prod        = x.tx_lvl * $signed({1'b0, mfm_pkg::mfm_gain(x.tx_ord)}); // RL14
        x.tx_scaled = prod[7:0];
        x.rx_bits   = mfm_pkg::mfm_demap(x.rx_ord, x.rx_lvl); // RL9 RL10 RL12 RL13
    end
endmodule : mfm_xlat
`default_nettype wire

/* File: mfm_sym_map_assertions.sv */
// Purpose: Port checks of the FSK symbol map
// Assumes: Bound to mfm_sym_map
// Notes:   None
`timescale 1ns/1ps
`default_nettype none
module mfm_sym_map_assertions #(
    parameter int MIN_SYM_CYC = 10000
) (
    input wire logic              mclk_i,
    input wire logic              sys_rst_i,
    input wire logic              reg_rd_i,
    input wire logic [31:0]       reg_rdata_o,
    input wire logic              tx_vld_i,
    input wire logic              tx_rdy_o,
    input wire logic              mod_vld_o,
    input wire logic signed [4:0] rx_lvl_i,
    input wire logic              rx_vld_i,
    input wire logic [3:0]        rx_bits_o,
    input wire logic [2:0]        rx_nbits_o,
    input wire logic              rx_vld_o,
    input wire logic [1:0]        rx_ord_o,
    input wire logic [5:0]        blk_len_o
);
    localparam logic [3:0] MAG [8] = '{4'h1, 4'h3, 4'h7, 4'h5, 4'hF, 4'hD, 4'h9, 4'hB};
    int gap_r;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    function automatic logic signed [4:0] lvl(input logic [1:0] o, input logic [3:0] b);
        logic [3:0] m;
        m = (o == 2'h0) ? 4'h3 : MAG[b[2:0] & 3'((4'h1 << o) - 4'h1)];
        return b[o] ? $signed({1'b0, m}) : -$signed({1'b0, m});
    endfunction : lvl
    // Cycles since last sample
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || mod_vld_o) begin
            gap_r <= 0;
        end else if (gap_r < MIN_SYM_CYC) begin
            gap_r <= gap_r + 1;
        end
    end
    sequence s_take;
        tx_vld_i && tx_rdy_o;
    endsequence
    AST_RST_STATE: assert property (disable iff (1'b0) $past(sys_rst_i) |->
        rx_ord_o == 2'h1 && !tx_rdy_o && !rx_vld_o && !mod_vld_o) else $error("reset state");
    AST_RD_IDLE: assert property (reg_rdata_o != 32'h0 |-> $past(reg_rd_i))
        else $error("read data without read");
    AST_TX_TAKE: assert property (s_take |=> !tx_rdy_o) else $error("ready held after take");
    AST_SYM_RATE: assert property (mod_vld_o |-> gap_r >= MIN_SYM_CYC / 2 - 1)
        else $error("samples too close");
    AST_RX_FOLLOW: assert property (rx_vld_o |-> $past(rx_vld_i))
        else $error("rx output without symbol");
    AST_RX_NBITS: assert property (rx_vld_o |-> rx_nbits_o == {1'b0, rx_ord_o} + 3'h1)
        else $error("rx group width wrong");
    AST_RX_MAP: assert property (rx_vld_o |-> lvl(rx_ord_o, rx_bits_o) == $past(rx_lvl_i))
        else $error("rx demap wrong");
    AST_BLK_MAX: assert property (blk_len_o <= 6'h30) else $error("block too long");
endmodule : mfm_sym_map_assertions
bind mfm_sym_map mfm_sym_map_assertions #(.MIN_SYM_CYC(MIN_SYM_CYC)) i_mfm_sym_map_assertions (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .tx_vld_i(tx_vld_i), .tx_rdy_o(tx_rdy_o), .mod_vld_o(mod_vld_o), .rx_lvl_i(rx_lvl_i),
    .rx_vld_i(rx_vld_i), .rx_bits_o(rx_bits_o), .rx_nbits_o(rx_nbits_o),
    .rx_vld_o(rx_vld_o), .rx_ord_o(rx_ord_o), .blk_len_o(blk_len_o));
`default_nettype wire

/* File: mfm_radio_model.sv */
// Purpose: Radio side handing symbol levels
// Assumes: One symbol per go_i pulse
// Notes:   Level held one cycle, then inverted
`timescale 1ns/1ps
`default_nettype none
module mfm_radio_model (
    input  wire logic         mclk_i,
    input  wire logic         go_i,
    input  wire logic [1:0]   ord_i,
    input  wire logic [3:0]   bits_i,
    output logic signed [4:0] rx_lvl_o,
    output logic              rx_vld_o
);
    localparam logic [3:0] MAG [8] = '{4'h1, 4'h3, 4'h7, 4'h5, 4'hF, 4'hD, 4'h9, 4'hB};
    function automatic logic signed [4:0] lvl(input logic [1:0] o, input logic [3:0] b);
        logic [3:0] m;
        m = (o == 2'h0) ? 4'h3 : MAG[b[2:0] & 3'((4'h1 << o) - 4'h1)];
        return b[o] ? $signed({1'b0, m}) : -$signed({1'b0, m});
    endfunction : lvl
    initial begin
        rx_lvl_o = 5'sh0;
        rx_vld_o = 1'b0;
    end
    always @(posedge mclk_i) begin
        rx_vld_o <= go_i;
        rx_lvl_o <= go_i ? lvl(ord_i, bits_i) : ~rx_lvl_o;
    end
endmodule : mfm_radio_model
`default_nettype wire

/* File: mfm_sym_map_test.sv */
// Purpose: Self-checking bench of the FSK symbol map
// Assumes: Short symbol period
// Notes:   One task per scenario
`timescale 1ns/1ps
`default_nettype none
`include "mfm_defs.svh"
module mfm_sym_map_test;
    logic mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, tx_hdr = 1'b0, tx_vld = 1'b0, go = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] tx_bits = 4'h0, bits = 4'h0, rx_bits;
    logic [1:0] ord = 2'h0, rx_ord, crc_sel;
    logic signed [17:0] mod;
    logic signed [4:0] rx_in_lvl;
    logic tx_rdy, mod_vld, rx_in_vld, rx_vld, fec_en, legacy_en;
    logic [2:0] rx_nbits;
    logic [5:0] blk_len;
    int bad_count = 0, n_checks = 0;
    mfm_sym_map #(.MIN_SYM_CYC(8)) i_mfm_sym_map (
        .mclk_i(mclk), .sys_rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .tx_bits_i(tx_bits), .tx_hdr_i(tx_hdr),
        .tx_vld_i(tx_vld), .tx_rdy_o(tx_rdy), .mod_o(mod), .mod_vld_o(mod_vld),
        .rx_lvl_i(rx_in_lvl), .rx_vld_i(rx_in_vld), .rx_bits_o(rx_bits), .rx_nbits_o(rx_nbits),
        .rx_vld_o(rx_vld), .rx_ord_o(rx_ord), .fec_en_o(fec_en), .legacy_en_o(legacy_en),
        .crc_sel_o(crc_sel), .blk_len_o(blk_len));
    mfm_radio_model i_mfm_radio_model (.mclk_i(mclk), .go_i(go), .ord_i(ord), .bits_i(bits),
        .rx_lvl_o(rx_in_lvl), .rx_vld_o(rx_in_vld));
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    task automatic do_reset();
        rst <= 1'b1;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
    endtask : do_reset
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        @(posedge mclk);
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk(rdata & m, e);
        @(posedge mclk);
    endtask : rd_chk
    task automatic send(input logic [1:0] o, input logic [3:0] b);
        ord <= o;
        bits <= b;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        @(posedge mclk);
        #1;
    endtask : send
    task automatic t_regs();
        logic [31:0] v [7] = '{`MFM_RST_MODE, `MFM_RST_MODSEL, `MFM_RST_SYNCMAP, `MFM_RST_SYNC1,
            `MFM_RST_SYNC2, 32'h0000_0008, 32'h0000_0000};
        for (int k = 0; k < 7; k++) begin
            rd_chk((k < 6) ? 8'(4 * k) : 8'h20, 32'hFFFF_FFFF, v[k]);
        end
        wr_reg(`MFM_OFS_RXLEN, 32'h0000_0000);
        rd_chk(`MFM_OFS_RXLEN, 32'hFFFF_FFFF, 32'h0000_0001);
    endtask : t_regs
    task automatic t_codes();
        for (int c = 0; c < 16; c++) begin
            wr_reg(`MFM_OFS_MODE, 32'(c) << 8);
            rd_chk(`MFM_OFS_STATUS, 32'h0000_0043, ((16'h2E34 >> c) & 1) ? 32'h1 : 32'h40);
        end
    endtask : t_codes
    task automatic t_ctl();
        for (int o = 0; o < 4; o++) begin
            wr_reg(`MFM_OFS_MODSEL, 32'(o));
            wr_reg(`MFM_OFS_MODE, 32'h003F_0236);
            #1;
            chk(32'({fec_en, legacy_en}), {30'h0, o != 0, o == 1});
            chk(32'({rx_ord, crc_sel, blk_len}), {22'h0, 2'h1, 2'h3, 6'h30});
            @(posedge mclk);
            rd_chk(`MFM_OFS_STATUS, 32'h0000_0080, 32'h0000_0080);
        end
    endtask : t_ctl
    task automatic t_rx(input logic [3:0] code, input logic [1:0] po, input logic [31:0] word,
        input logic [1:0] eo);
        logic [3:0] b;
        wr_reg(`MFM_OFS_MODSEL, {30'h0, po});
        wr_reg(`MFM_OFS_RXLEN, 32'h0000_0010);
        wr_reg(`MFM_OFS_MODE, {20'h0, code, 8'h00});
        for (int i = 15; i >= 0; i--) begin
            send(2'h1, {2'h0, word[2 * i +: 2]});
            chk(32'(rx_vld), 32'h0);
        end
        for (int i = 0; i < 16; i++) begin
            b = 4'(i) & 4'((5'h2 << eo) - 5'h1);
            send(eo, b);
            chk({rx_vld, rx_ord, rx_nbits, rx_bits}, {1'b1, eo, {1'b0, eo} + 3'h1, b});
        end
        @(posedge mclk);
    endtask : t_rx
    task automatic t_tx();
        logic [1:0] po [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
        logic [4:0] hb [5] = '{5'h01, 5'h03, 5'h06, 5'h0C, 5'h13};
        logic signed [17:0] peak;
        for (int k = 0; k < 5; k++) begin
            do_reset();
            wr_reg(`MFM_OFS_SYMPER, 32'h0000_0008);
            wr_reg(`MFM_OFS_MODSEL, {30'h0, po[k]});
            wr_reg(`MFM_OFS_MODE, 32'h0000_0001);
            for (int w = 0; w < 50 && tx_rdy !== 1'b1; w++) begin
                @(posedge mclk);
                #1;
            end
            chk(32'(tx_rdy), 32'h1);
            @(posedge mclk);
            {tx_hdr, tx_bits} <= hb[k];
            tx_vld <= 1'b1;
            @(posedge mclk);
            tx_vld <= 1'b0;
            peak = '0;
            repeat (80) begin
                @(posedge mclk);
                #1;
                if (mod_vld === 1'b1 && mod > peak) peak = mod;
            end
            chk(32'(peak), 32'(18'sd127 * 18'sd105));
            @(posedge mclk);
        end
    endtask : t_tx
    initial begin
        do_reset();
        t_regs();
        t_codes();
        t_ctl();
        for (int o = 0; o < 4; o++) begin
            t_rx(4'h4, 2'(o), `MFM_RST_SYNC1, 2'(o));
        end
        t_rx(4'h5, 2'h2, `MFM_RST_SYNC2, 2'h2);
        t_rx(4'hD, 2'h0, `MFM_RST_SYNC2, 2'h3);
        t_rx(4'hD, 2'h0, `MFM_RST_SYNC1, 2'h1);
        t_tx();
        close_out();
    end
    initial begin
        #100us;
        bad_count++;
        close_out();
    end
endmodule : mfm_sym_map_test
`default_nettype wire
